// *** hw/nav_sensor_serial_port.sv ***
/*
  Serial slave port of the motion sensor with motion status, delta
  accumulation, alert line, full reset and power-down control.
  Assumes pins from outside the clock domain and a core motion strobe
  on this clock.
*/
`timescale 1ns/10ps
`include "nav_map.svh"
module nav_sensor_serial_port (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  // Host serial pins
  input  wire logic            spi_sclk,
  input  wire logic            spi_ncs_n,
  input  wire logic            spi_mosi,
  output logic                 spi_miso,
  output logic                 spi_miso_oe,
  // Motion alert pin
  output logic                 motion_n,
  // Sensor core motion
  input  wire logic            core_motion,
  input  wire nav_pkg::byte_t  core_dx,
  input  wire nav_pkg::byte_t  core_dy,
  // Power and rest state
  output logic                 power_down,
  output logic                 sensor_reset,
  output nav_pkg::rest_level_t rest_level,
  output logic                 frame_req
);
  import nav_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] sclk_q;
  logic [1:0] ncs_q;
  logic [1:0] mosi_q;

  // Two flops before use; the third sclk stage only feeds edge detect
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 3'h7; // Idle high, so no false edge after reset
      ncs_q  <= 2'h3;
      mosi_q <= 2'h0;
    end else if (clk_en) begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      ncs_q  <= {ncs_q[0], spi_ncs_n};
      mosi_q <= {mosi_q[0], spi_mosi};
    end
  end

  // Edges and levels seen by the port
  wire sck_rise = sclk_q[1] & ~sclk_q[2];
  wire sck_fall = ~sclk_q[1] & sclk_q[2];
  wire sel      = ~ncs_q[1];
  wire mosi_s   = mosi_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Byte engine

  spi_state_t state;
  logic [2:0] bitcnt;
  byte_t      shreg;
  addr_t      addr;
  logic       wr_stb;
  byte_t      wr_data;
  logic       rd_stb;
  logic       fetch;
  byte_t      tx;

  // Decode of the byte just completed
  wire   byte_end    = sel & sck_rise & (bitcnt == 3'h7);
  wire   byte_t next_shreg = {shreg[6:0], mosi_s}; // [RULE27]
  wire   addr_done   = byte_end & (state == ST_ADDR);
  wire   is_write    = next_shreg[7]; // [RULE5] [RULE7]
  wire   data_done   = byte_end & (state == ST_WDATA);

  // Shift and count; select high drops any partial transfer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state  <= ST_ADDR;
      bitcnt <= 3'h0;
      shreg  <= 8'h00;
      addr   <= 7'h00;
    end else if (clk_en) begin
      if (!sel) begin // [RULE2] [RULE3]
        state  <= ST_ADDR;
        bitcnt <= 3'h0;
      end else if (sck_rise) begin // [RULE6]
        shreg  <= next_shreg;
        bitcnt <= bitcnt + 3'h1;
        if (bitcnt == 3'h7) begin
          unique case (state)
            ST_ADDR: begin
              addr  <= next_shreg[6:0];
              state <= is_write ? ST_WDATA : ST_RDATA; // [RULE5] [RULE7]
            end
            ST_WDATA: state <= ST_ADDR;
            ST_RDATA: state <= ST_ADDR;
          endcase
        end
      end
    end
  end

  // Write and read strobes, one cycle each
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
      rd_stb  <= 1'b0;
      fetch   <= 1'b0;
    end else if (clk_en) begin
      wr_stb  <= data_done; // [RULE5]
      wr_data <= data_done ? next_shreg : wr_data;
      rd_stb  <= addr_done & ~is_write; // [RULE7]
      fetch   <= rd_stb;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register side

  logic  move_flag;
  byte_t dx;
  byte_t dy;
  logic  x_done;
  logic  y_done;
  logic  force_run;
  logic  soft_rst;
  byte_t mem_rd;
  byte_t rest_rd;

  // Write decode
  wire wr_move  = wr_stb & (addr == `A_MOVE);
  wire wr_reset = wr_stb & (addr == `A_RESET) & (wr_data == `RESET_CODE);
  wire wr_pd    = wr_stb & (addr == `A_MOUSE) & (wr_data == `PD_CODE);
  wire wr_led   = wr_stb & (addr == `A_LED_CFG);
  wire mem_we   = wr_stb & (addr != `A_MOVE) & (addr != `A_RESET); // [RULE26]

  // Read decode; a powered-down port answers with zeros
  wire   in_rest = (addr >= `A_RUN_DS) & (addr <= `A_REST3_PER);
  wire   byte_t rd_mux = power_down         ? 8'h00 : // [RULE19]
                         addr == `A_MOVE    ? {move_flag, 7'h00} :
                         addr == `A_DX      ? dx :
                         addr == `A_DY      ? dy :
                         in_rest            ? rest_rd : mem_rd;

  nav_reg_mem u_mem (
    .clock   (clock),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .clear   (soft_rst),
    .wr_en   (mem_we),
    .wr_addr (addr),
    .wr_data (wr_data),
    .rd_en   (rd_stb),
    .rd_addr (addr),
    .rd_data (mem_rd)
  );

  nav_rest_ctrl u_rest (
    .clock       (clock),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .soft_rst    (soft_rst),
    .wireless_en (~force_run),
    .motion_seen (core_motion),
    .wr_stb      (wr_stb),
    .wr_addr     (addr),
    .wr_data     (wr_data),
    .rd_addr     (addr),
    .rd_data     (rest_rd),
    .rest_level  (rest_level),
    .frame_req   (frame_req)
  );

  ////////////////////////////////////////////////////////////////////////
  // Serial output

  // Bit leaves on the falling edge and stands until the next one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx          <= 8'h00;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (clk_en) begin
      if (fetch) tx <= rd_mux;
      if (!sel) begin
        spi_miso_oe <= 1'b0; // [RULE2]
      end else if (sck_fall) begin
        if (state == ST_RDATA) begin // [RULE1] [RULE8]
          spi_miso    <= tx[7]; // [RULE27]
          tx          <= {tx[6:0], 1'b0};
          spi_miso_oe <= 1'b1;
        end else begin
          spi_miso_oe <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Motion status

  // Read-out of X and Y counts only while motion is pending
  wire rd_x     = fetch & (addr == `A_DX) & move_flag;
  wire rd_y     = fetch & (addr == `A_DY) & move_flag;
  wire all_read = (rd_x | x_done) & (rd_y | y_done); // [RULE16]
  wire clr_mv   = wr_move | all_read | soft_rst; // [RULE26] [RULE17]

  // New motion wins over a clear in the same cycle
  wire byte_t next_dx   = (clr_mv ? 8'h00 : dx) + (core_motion ? core_dx : 8'h00);
  wire byte_t next_dy   = (clr_mv ? 8'h00 : dy) + (core_motion ? core_dy : 8'h00);
  wire        next_flag = core_motion | (move_flag & ~clr_mv);
  wire        next_xd   = ~clr_mv & ~core_motion & (x_done | rd_x);
  wire        next_yd   = ~clr_mv & ~core_motion & (y_done | rd_y);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      move_flag <= 1'b0;
      motion_n  <= 1'b1;
      dx        <= 8'h00;
      dy        <= 8'h00;
      x_done    <= 1'b0;
      y_done    <= 1'b0;
    end else if (clk_en) begin
      move_flag <= next_flag;
      motion_n  <= ~next_flag; // [RULE15]
      dx        <= next_dx;
      dy        <= next_dy;
      x_done    <= next_xd;
      y_done    <= next_yd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset and power control

  // Full reset strobe wipes settings; also the only way out of power-down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst     <= 1'b0;
      sensor_reset <= 1'b0;
      power_down   <= 1'b0;
      force_run    <= 1'b0;
    end else if (clk_en) begin
      soft_rst     <= wr_reset; // [RULE17]
      sensor_reset <= wr_reset;
      if (wr_reset) begin
        power_down <= 1'b0;
        force_run  <= 1'b0;
      end else begin
        if (wr_pd) power_down <= 1'b1; // [RULE19]
        if (wr_led) force_run <= wr_data[`FORCE_RUN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_addr_byte;
    clk_en && addr_done;
  endsequence
  sequence s_fetch_pair;
    rd_stb ##1 fetch;
  endsequence

  a_miso_release: assert property (clk_en && !sel |=> !spi_miso_oe) // [RULE2]
    else $error("data output driven while deselected");
  a_abort_idle: assert property (clk_en && !sel |=> state == ST_ADDR && bitcnt == 3'h0) // [RULE3]
    else $error("port not idle after deselect");
  a_write_dir: assert property (s_addr_byte and is_write |=> state == ST_WDATA) // [RULE5]
    else $error("write address not followed by data phase");
  a_read_fetch: assert property (s_addr_byte and !is_write |=> s_fetch_pair) // [RULE7]
    else $error("read address did not fetch data");
  a_mosi_sample: assert property (clk_en && sel && sck_rise |=> shreg[0] == $past(mosi_s)) // [RULE6]
    else $error("host data not sampled on rising edge");
  a_miso_shift: assert property (clk_en && sel && sck_fall && state == ST_RDATA // [RULE8]
    |=> spi_miso == $past(tx[7]) && spi_miso_oe)
    else $error("read bit not shifted out on falling edge");
  a_miso_hold: assert property (clk_en && !sck_fall |=> $stable(spi_miso)) // [RULE8]
    else $error("data output changed away from falling edge");
  a_alert_level: assert property (move_flag |-> !motion_n) // [RULE15]
    else $error("alert high while motion pending");
  a_alert_clear: assert property (clk_en && all_read && !core_motion // [RULE16]
    |=> !move_flag && motion_n && dx == 8'h00 && dy == 8'h00)
    else $error("motion not cleared after deltas read");
  a_move_write: assert property (clk_en && wr_move && !core_motion // [RULE26]
    |=> !move_flag && dx == 8'h00 && dy == 8'h00)
    else $error("status write did not clear motion");
  a_soft_reset: assert property (clk_en && wr_reset |=> sensor_reset && !power_down) // [RULE17]
    else $error("reset code did not reset");
  a_power_down: assert property (clk_en && wr_pd |=> power_down) // [RULE19]
    else $error("power-down code ignored");
endmodule : nav_sensor_serial_port

// *** hw/nav_map.svh ***
/*
  Register offsets, codes, reset values and timing counts of the serial port.
  Assumes inclusion by bare name from every design file that needs them.
*/
// Notes on behaviour
// RULE1: Only the host starts a transfer; the port never drives unasked.
// RULE2: Select high: clock and data ignored, data output released.
// RULE3: Select raised mid-transfer drops it; port waits for a fresh address.
// RULE4: Host still keeps the usual gaps after an aborted transfer.
// RULE5: Write is address byte with top bit 1, then one data byte.
// RULE6: Host data is sampled on every rising serial clock edge.
// RULE7: Read is address byte with top bit 0, then port sends one byte.
// RULE8: Read data changes on falling edges, holds until the next one.
// RULE9: Host leaves the write-to-write gap between final data bits.
// RULE10: Host leaves the write-to-read gap before the read's last address bit.
// RULE11: Host pauses the clock the address-to-data delay in a read.
// RULE12: Host leaves the read-to-next gap after a read's data byte.
// RULE13: Flag polling only when wired; wireless hosts use the alert line.
// RULE14: Poll status, then X and Y back to back; part check afterwards.
// RULE15: Alert line low as a level while motion is pending.
// RULE16: Once X and Y are read, zero both, clear flag, alert high.
// RULE17: Reset code written to the reset register resets everything.
// RULE18: Host power-up: toggle select, reset, wait, two fixed writes.
// RULE19: Power-down code to mouse control powers down; reads meaningless.
// RULE20: Host leaves power-down with a reset, wake wait and reload.
// RULE21: Wireless mode steps through three rest levels by idle time.
// RULE22: Host enables wireless by clearing force_run and fixed writes.
// RULE23: Write-to-write gap is 30 us at least.
// RULE24: Address-to-data pause in a read is 4 us at least.
// RULE25: Wake-up wait after the reset write is 50 to 55 ms.
// RULE26: Writing the status register clears flag and both deltas, stores nothing.
// RULE27: All bytes travel most significant bit first.
`ifndef NAV_MAP_SVH
`define NAV_MAP_SVH
// Register offsets
`define A_PART      7'h00
`define A_SHUT_HI   7'h06
`define A_MOVE      7'h02
`define A_DX        7'h03
`define A_DY        7'h04
`define A_MOUSE     7'h0D
`define A_RUN_DS    7'h0E
`define A_REST3_PER 7'h13
`define A_SHUT_THR  7'h1C
`define A_SQUAL_THR 7'h1D
`define A_LED_CFG   7'h22
`define A_MISC      7'h25
`define A_RESOL     7'h33
`define A_PRECHG    7'h34
`define A_RESET     7'h3A
`define A_NREV      7'h3F
// Codes and field positions
`define RESET_CODE  8'h5A
`define PD_CODE     8'h02
`define FORCE_RUN_BIT 0
// Reset values
`define D_SHUT_HI   8'h01
`define D_MOUSE     8'h01
`define D_SHUT_THR  8'h41
`define D_SQUAL_THR 8'h3D
`define D_MISC      8'h61
`define D_RESOL     8'h04
`define D_PRECHG    8'hA0
`define D_NREV      8'hFF
`define D_RUN_DS    8'h46
`define D_R1_PER    8'h00
`define D_R1_DS     8'h4F
`define D_R2_PER    8'h09
`define D_R2_DS     8'h2F
`define D_R3_PER    8'h31
// Timing
`define CLOCK_NS     10
`define REST_TICK_NS 10000
`define REST_TICK_CYC (`REST_TICK_NS / `CLOCK_NS)
`endif

// *** hw/nav_pkg.sv ***
/*
  Types shared by the serial port, register store and rest controller.
  Assumes nothing of its surroundings.
*/
package nav_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] addr_t;
  typedef enum logic [1:0] {ST_ADDR, ST_WDATA, ST_RDATA} spi_state_t;
  typedef enum logic [1:0] {LV_RUN, LV_REST1, LV_REST2, LV_REST3} rest_level_t;
endpackage : nav_pkg

// *** hw/nav_reg_mem.sv ***
/*
  General register store, 128 bytes, registered read, defaults until written.
  Assumes one write and one read strobe per cycle from the serial port.
*/
`timescale 1ns/10ps
`include "nav_map.svh"
module nav_reg_mem (
  // Clock and control
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire logic          clear,
  // Write side
  input  wire logic          wr_en,
  input  wire nav_pkg::addr_t wr_addr,
  input  wire nav_pkg::byte_t wr_data,
  // Read side
  input  wire logic          rd_en,
  input  wire nav_pkg::addr_t rd_addr,
  output nav_pkg::byte_t     rd_data
);
  import nav_pkg::*;
  localparam byte_t PART_CODE = 8'h5C; // Arbitrary value

  byte_t        store [128];
  logic [127:0] written;

  // Power-on contents; no reset on the array itself saves area
  function automatic byte_t def_val(input addr_t a);
    unique case (a)
      `A_PART:      def_val = PART_CODE;
      `A_SHUT_HI:   def_val = `D_SHUT_HI;
      `A_MOUSE:     def_val = `D_MOUSE;
      `A_SHUT_THR:  def_val = `D_SHUT_THR;
      `A_SQUAL_THR: def_val = `D_SQUAL_THR;
      `A_MISC:      def_val = `D_MISC;
      `A_RESOL:     def_val = `D_RESOL;
      `A_PRECHG:    def_val = `D_PRECHG;
      `A_NREV:      def_val = `D_NREV;
      default:      def_val = 8'h00;
    endcase
  endfunction : def_val

  // Written marks, one per entry, wiped by a full reset
  for (genvar i = 0; i < 128; i++) begin : g_mark
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) written[i] <= 1'b0;
      else if (clk_en && clear) written[i] <= 1'b0;
      else if (clk_en && wr_en && wr_addr == 7'(i)) written[i] <= 1'b1;
    end
  end

  // Array write
  always_ff @(posedge clock) begin
    if (clk_en && wr_en) store[wr_addr] <= wr_data;
  end

  // Registered read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rd_data <= 8'h00;
    else if (clk_en && rd_en) rd_data <= written[rd_addr] ? store[rd_addr] : def_val(rd_addr);
  end
endmodule : nav_reg_mem

// *** hw/nav_rest_ctrl.sv ***
/*
  Rest level controller: six rest config bytes, downshift and frame pacing.
  Assumes write strobes from the serial port and a motion strobe from the core.
*/
`timescale 1ns/10ps
`include "nav_map.svh"
module nav_rest_ctrl (
  // Clock and control
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  input  wire logic            soft_rst,
  input  wire logic            wireless_en,
  input  wire logic            motion_seen,
  // Register access
  input  wire logic            wr_stb,
  input  wire nav_pkg::addr_t  wr_addr,
  input  wire nav_pkg::byte_t  wr_data,
  input  wire nav_pkg::addr_t  rd_addr,
  output nav_pkg::byte_t       rd_data,
  // Status
  output nav_pkg::rest_level_t rest_level,
  output logic                 frame_req
);
  import nav_pkg::*;
  localparam byte_t CFG_DEF [6] = '{`D_RUN_DS, `D_R1_PER, `D_R1_DS,
                                    `D_R2_PER, `D_R2_DS, `D_R3_PER};
  byte_t       cfg [6];
  logic [9:0]  tick_cnt;
  byte_t       lvl_cnt;
  byte_t       per_cnt;
  rest_level_t next_level;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Config bytes, one per register
  for (genvar i = 0; i < 6; i++) begin : g_cfg
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) cfg[i] <= CFG_DEF[i];
      else if (clk_en && soft_rst) cfg[i] <= CFG_DEF[i];
      else if (clk_en && wr_stb && wr_addr == 7'(`A_RUN_DS + i)) cfg[i] <= wr_data;
    end
  end

  // Readback and level decode
  wire addr_t off      = rd_addr - `A_RUN_DS;
  wire        tick     = tick_cnt == 10'(`REST_TICK_CYC - 1);
  wire byte_t cur_ds   = rest_level == LV_RUN ? cfg[0] :
                         rest_level == LV_REST1 ? cfg[2] : cfg[4];
  wire byte_t cur_per  = rest_level == LV_REST1 ? cfg[1] :
                         rest_level == LV_REST2 ? cfg[3] :
                         rest_level == LV_REST3 ? cfg[5] : 8'h00;
  wire        go_down  = tick && rest_level != LV_REST3 && lvl_cnt >= cur_ds;
  wire        per_done = tick && per_cnt >= cur_per;
  assign rd_data = off < 7'h06 ? cfg[off[2:0]] : 8'h00;

  always_comb begin
    unique case (rest_level)
      LV_RUN:   next_level = LV_REST1;
      LV_REST1: next_level = LV_REST2;
      LV_REST2: next_level = LV_REST3;
      LV_REST3: next_level = LV_REST3;
    endcase
  end

  // Idle time walks the levels down; motion snaps back to run
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt   <= 10'h000;
      rest_level <= LV_RUN;
      lvl_cnt    <= 8'h00;
      per_cnt    <= 8'h00;
      frame_req  <= 1'b0;
    end else if (clk_en) begin
      tick_cnt  <= tick ? 10'h000 : tick_cnt + 10'h001;
      frame_req <= per_done;
      per_cnt   <= per_done ? 8'h00 : per_cnt + {7'h00, tick};
      if (soft_rst || motion_seen || !wireless_en) begin // [RULE21]
        rest_level <= LV_RUN;
        lvl_cnt    <= 8'h00;
      end else if (go_down) begin
        rest_level <= next_level;
        lvl_cnt    <= 8'h00;
      end else if (tick && lvl_cnt != 8'hFF) begin
        lvl_cnt <= lvl_cnt + 8'h01;
      end
    end
  end

  a_rest_wake: assert property (clk_en && motion_seen |=> rest_level == LV_RUN) // [RULE21]
    else $error("rest level not back to run after motion");
  a_rest_step: assert property (clk_en && go_down && wireless_en && !motion_seen && !soft_rst // [RULE21]
    |=> rest_level != $past(rest_level) && lvl_cnt == 8'h00)
    else $error("rest level did not step down");
endmodule : nav_rest_ctrl

// *** dv/nav_host_model.sv ***
/*
  Host-side serial master: drives clock, select and data out, samples data in.
  Assumes the bench calls its tasks and hands it the resolved data-in wire.
*/
`timescale 1ns/10ps
module nav_host_model #(
  parameter int HALF   = 4,
  parameter int GAP_WW = 3000,
  parameter int GAP_AD = 400,
  parameter int GAP_RN = 25
) (
  // Clock and pins
  input  wire logic clock,
  output logic      spi_sclk,
  output logic      spi_ncs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // Idle: select high, serial clock parked high
  initial begin
    spi_sclk = 1'b1;
    spi_ncs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_clk

  ////////////////////////////////////////////////////////////////////////
  // Bits leave MSB first; input sampled late in the high phase
  task automatic shift_byte(input logic [7:0] tx, input int nbits,
                            output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      spi_sclk = 1'b0;
      spi_mosi = tx[i];
      wait_clk(HALF);
      spi_sclk = 1'b1;
      wait_clk(HALF);
      rx[i] = spi_miso;
    end
  endtask : shift_byte

  // Short nbits drops select mid-transfer to abort it
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data,
                           input int nbits = 16);
    logic [7:0] rx;
    spi_ncs_n = 1'b0;
    wait_clk(HALF);
    shift_byte({1'b1, addr}, (nbits > 8) ? 8 : nbits, rx);
    if (nbits > 8) shift_byte(data, nbits - 8, rx);
    wait_clk(8);
    spi_ncs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    wait_clk(GAP_WW);
  endtask : write_reg

  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    logic [7:0] rx;
    spi_ncs_n = 1'b0;
    wait_clk(HALF);
    shift_byte({1'b0, addr}, 8, rx);
    wait_clk(GAP_AD);
    shift_byte(8'hC3, 8, data);
    spi_ncs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    wait_clk(GAP_RN);
  endtask : read_reg
endmodule : nav_host_model

// *** dv/tb_nav_sensor_serial_port.sv ***
/*
  Self-checking bench of the sensor serial port, driven through the host model.
  Assumes the design package and register map header are compiled first.
*/
`timescale 1ns/10ps
`include "nav_map.svh"
module tb_nav_sensor_serial_port;
  import nav_pkg::*;
  logic        clock, rst_n, core_motion, spi_sclk, spi_ncs_n, spi_mosi;
  logic        spi_miso, spi_miso_oe, motion_n, power_down, sensor_reset;
  logic        frame_req, rst_seen;
  byte_t       core_dx, core_dy, rd;
  rest_level_t rest_level;
  wire         miso_w = spi_miso_oe ? spi_miso : 1'bz;
  int          n_mismatch, checks_done, cycles, ncs_hi, gap;

  nav_sensor_serial_port dut_u (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .spi_sclk(spi_sclk), .spi_ncs_n(spi_ncs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .motion_n(motion_n),
    .core_motion(core_motion), .core_dx(core_dx), .core_dy(core_dy),
    .power_down(power_down), .sensor_reset(sensor_reset),
    .rest_level(rest_level), .frame_req(frame_req));
  nav_host_model host_u (.clock(clock), .spi_sclk(spi_sclk),
    .spi_ncs_n(spi_ncs_n), .spi_mosi(spi_mosi), .spi_miso(miso_w));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog plus idle-bus and reset-strobe monitors
  always @(negedge clock) begin
    cycles++;
    ncs_hi = spi_ncs_n ? ncs_hi + 1 : 0;
    if (sensor_reset === 1'b1) rst_seen = 1'b1;
    if (ncs_hi > 4 && spi_miso_oe !== 1'b0) begin
      n_mismatch++;
      $display("wrong value miso_oe expected 0 seen %b", spi_miso_oe);
    end
    if (cycles == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
    host_u.read_reg(addr, rd);
    check($sformatf("reg %h", addr), exp, rd);
  endtask : rd_chk

  // One-cycle core strobe, then let the flag settle
  task automatic core_move(input byte_t dx, input byte_t dy);
    core_motion = 1'b1;
    core_dx = dx;
    core_dy = dy;
    @(negedge clock);
    core_motion = 1'b0;
    repeat (2) @(negedge clock);
  endtask : core_move

  // Clocks from one frame request to the next; watchdog covers a hang
  task automatic frame_gap(output int n);
    n = 0;
    while (frame_req !== 1'b1) @(negedge clock);
    do begin
      n++;
      @(negedge clock);
    end while (frame_req !== 1'b1 && n < 3000);
  endtask : frame_gap

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; inputs only change on falling clock edges
  initial begin
    {rst_n, core_motion, core_dx, core_dy, rst_seen} = '0;
    {n_mismatch, checks_done, cycles, ncs_hi} = '0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    check("oe", 8'h00, {7'h00, spi_miso_oe});
    check("motion_n", 8'h01, {7'h00, motion_n});
    rd_chk(`A_SHUT_HI, `D_SHUT_HI);
    host_u.write_reg(`A_SHUT_THR, 8'hA5);
    rd_chk(`A_SHUT_THR, 8'hA5);
    host_u.write_reg(`A_SHUT_THR, 8'h3C, 12);
    rd_chk(`A_SHUT_THR, 8'hA5);
    // Wired mode first: polling allowed, no downshift
    host_u.write_reg(`A_LED_CFG, 8'h01);
    // Two strobes accumulate; alert stays low until both deltas are read
    core_move(8'h01, 8'hFE);
    core_move(8'h02, 8'h00);
    check("motion_n", 8'h00, {7'h00, motion_n});
    host_u.read_reg(`A_MOVE, rd);
    check("move_flag", 8'h80, rd & 8'h80);
    rd_chk(`A_DX, 8'h03);
    check("motion_n", 8'h00, {7'h00, motion_n});
    rd_chk(`A_DY, 8'hFE);
    check("motion_n", 8'h01, {7'h00, motion_n});
    rd_chk(`A_DX, 8'h00);
    core_move(8'h05, 8'h05);
    host_u.write_reg(`A_MOVE, 8'hFF);
    check("motion_n", 8'h01, {7'h00, motion_n});
    rd_chk(`A_MOVE, 8'h00);
    rd_chk(`A_DY, 8'h00);
    // Wired: held in run despite a one-tick downshift, one request per tick
    host_u.write_reg(`A_RUN_DS, 8'h01);
    check("rest_level", {6'h00, LV_RUN}, {6'h00, rest_level});
    frame_gap(gap);
    checks_done++;
    if (gap != `REST_TICK_CYC) begin
      n_mismatch++;
      $display("wrong value frame_gap expected %0d seen %0d", `REST_TICK_CYC, gap);
    end
    // Wireless set-up; downshift after one tick, motion pulls back to run
    host_u.write_reg(`A_LED_CFG, 8'h00);
    host_u.write_reg(7'h35, 8'h26);
    host_u.write_reg(7'h14, 8'h30);
    host_u.write_reg(7'h18, 8'h30);
    host_u.write_reg(7'h43, 8'h01);
    host_u.write_reg(7'h40, 8'h01);
    for (int i = 0; i < 2500 && rest_level !== LV_REST1; i++) @(negedge clock);
    check("rest_level", {6'h00, LV_REST1}, {6'h00, rest_level});
    core_move(8'h00, 8'h00);
    check("rest_level", {6'h00, LV_RUN}, {6'h00, rest_level});
    check("motion_n", 8'h00, {7'h00, motion_n});
    // Power-down, then leave it by full reset and reload
    host_u.write_reg(`A_MOUSE, `PD_CODE);
    check("power_down", 8'h01, {7'h00, power_down});
    // Wake wait kept short: this model answers one write gap after reset
    host_u.write_reg(`A_RESET, `RESET_CODE);
    check("sensor_reset", 8'h01, {7'h00, rst_seen});
    check("power_down", 8'h00, {7'h00, power_down});
    rd_chk(`A_SHUT_THR, `D_SHUT_THR);
    rd_chk(`A_RUN_DS, `D_RUN_DS);
    host_u.write_reg(`A_MOUSE, 8'h20);
    host_u.write_reg(7'h41, 8'h00);
    rd_chk(`A_MOUSE, 8'h20);
    end_sim();
  end
endmodule : tb_nav_sensor_serial_port
